// ---- hw/edge_if.sv ----
// pin levels and polarity going to the edge detector, events coming back
// assumes one clock domain shared by both ends
interface edge_if;
   import gpio_pkg::*;
   pins_t pins;
   pins_t polarity;
   pins_t events;
   modport det (input pins, input polarity, output events);
   modport ctl (output pins, output polarity, input events);
endinterface

// ---- hw/gpio_irq_pull_regs.sv ----
// apb register block: interrupt polarity, pending flags, soft reset bypass, pulls
// assumes apb master on CORE_CLK, pins synchronous, SOFT_RST a one-cycle pulse
//
// The APB interface to the registers is this design's own decision.
module gpio_irq_pull_regs (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic SOFT_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire gpio_pkg::addr_t PADDR,
   input wire gpio_pkg::word_t PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire gpio_pkg::pins_t PIN_IN,
   output gpio_pkg::pins_t PULL_EN,
   output gpio_pkg::pins_t PULL_UP,
   output logic IRQ
);
   import gpio_pkg::*;

   typedef enum logic {AP_IDLE, AP_ANSWER} apb_state_e;

   apb_state_e state_q;
   word_t prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   pins_t pol_q;
   pins_t pending_q;
   pins_t pull_en_q;
   pins_t pull_dir_q;
   pins_t mask_q;
   logic bypass_q;

   logic fire;
   logic wr_fire;
   logic mapped;
   logic soft_kill;
   word_t rd_mux;
   pins_t wr_pins;
   pins_t pin_events;

   edge_if edges ();

   assign edges.pins = PIN_IN;
   assign edges.polarity = pol_q;
   assign pin_events = edges.events;

   pin_edge_detect u_detect (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .port(edges.det)
   );

   // one wait state: the answer comes at the second access cycle
   assign fire = (state_q == AP_ANSWER) & PSEL & PENABLE;
   assign wr_fire = fire & PWRITE & ~pslverr_q;
   assign wr_pins = PWDATA[PIN_MSB:PIN_LSB];
   // soft reset only bites while the bypass bit is clear
   assign soft_kill = SOFT_RST & ~bypass_q;

   always_comb begin
      mapped = 1'b1;
      rd_mux = RST_RDATA;
      case (PADDR)
         OFS_POL_SET: rd_mux = {RSVD_HIGH, pol_q};
         OFS_POL_CLEAR: rd_mux = {RSVD_HIGH, pol_q};
         OFS_IRQ_STATUS: rd_mux = {RSVD_HIGH, pending_q};
         OFS_SOFT_RESET: rd_mux = {31'h0000_0000, bypass_q};
         OFS_PULL_ENABLE: rd_mux = {RSVD_HIGH, pull_en_q};
         OFS_PULL_DIR: rd_mux = {RSVD_HIGH, pull_dir_q};
         OFS_IRQ_MASK: rd_mux = {RSVD_HIGH, mask_q};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_q <= AP_IDLE;
         pready_q <= 1'b0;
      end else begin
         case (state_q)
            AP_IDLE: begin
               if (PSEL & PENABLE) begin
                  state_q <= AP_ANSWER;
                  pready_q <= 1'b1;
               end
            end
            AP_ANSWER: begin
               state_q <= AP_IDLE;
               pready_q <= 1'b0;
            end
            default: begin
               state_q <= AP_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   // read data and error are loaded with pready so they leave a flop
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         prdata_q <= RST_RDATA;
         pslverr_q <= 1'b0;
      end else if (state_q == AP_IDLE && PSEL && PENABLE) begin
         prdata_q <= PWRITE ? RST_RDATA : rd_mux;
         pslverr_q <= ~mapped;
      end else begin
         prdata_q <= RST_RDATA;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pol_q <= RST_POL;
      end else if (soft_kill) begin
         pol_q <= RST_POL;
      end else if (wr_fire && PADDR == OFS_POL_SET) begin
         pol_q <= pol_q | wr_pins;
      end else if (wr_fire && PADDR == OFS_POL_CLEAR) begin
         pol_q <= pol_q & ~wr_pins;
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pending_q <= RST_PENDING;
      end else if (soft_kill) begin
         pending_q <= pin_events;
      end else if (wr_fire && PADDR == OFS_IRQ_STATUS) begin
         pending_q <= (pending_q & ~wr_pins) | pin_events;
      end else begin
         pending_q <= pending_q | pin_events;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         bypass_q <= RST_BYPASS;
      end else if (wr_fire && PADDR == OFS_SOFT_RESET) begin
         bypass_q <= PWDATA[BYPASS_BIT];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pull_en_q <= RST_PULL_ENABLE;
      end else if (soft_kill) begin
         pull_en_q <= RST_PULL_ENABLE;
      end else if (wr_fire && PADDR == OFS_PULL_ENABLE) begin
         pull_en_q <= wr_pins;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pull_dir_q <= RST_PULL_DIR;
      end else if (soft_kill) begin
         pull_dir_q <= RST_PULL_DIR;
      end else if (wr_fire && PADDR == OFS_PULL_DIR) begin
         pull_dir_q <= wr_pins;
      end
   end

   // the mask is software policy, so soft reset leaves it alone
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         mask_q <= RST_MASK;
      end else if (wr_fire && PADDR == OFS_IRQ_MASK) begin
         mask_q <= wr_pins;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(pending_q & mask_q);
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PULL_EN = pull_en_q;
   assign PULL_UP = pull_dir_q;
   assign IRQ = irq_q;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (SYS_RST);

   pol_clear_a: assert property (
      (wr_fire && PADDR == OFS_POL_CLEAR && !soft_kill)
      |=> ((pol_q & $past(wr_pins)) == 16'h0000)
          && ((pol_q & ~$past(wr_pins)) == ($past(pol_q) & ~$past(wr_pins))))
      else $error("polarity clear wrong");

   pol_read_a: assert property (
      (fire && !PWRITE && PADDR == OFS_POL_CLEAR)
      |-> (PRDATA == {RSVD_HIGH, $past(pol_q)}) && !PSLVERR)
      else $error("polarity readback wrong");

   pend_clear_a: assert property (
      (wr_fire && PADDR == OFS_IRQ_STATUS && !soft_kill)
      |=> ((pending_q & $past(wr_pins) & ~$past(pin_events)) == 16'h0000)
          && ((pending_q & ~$past(wr_pins)) == (($past(pending_q) | $past(pin_events)) & ~$past(wr_pins))))
      else $error("pending clear wrong");

   pend_set_a: assert property (
      (pin_events != 16'h0000) |=> ((pending_q & $past(pin_events)) == $past(pin_events)))
      else $error("pending event lost");

   pend_read_a: assert property (
      (fire && !PWRITE && PADDR == OFS_IRQ_STATUS)
      |-> PRDATA == {RSVD_HIGH, $past(pending_q)})
      else $error("pending readback wrong");

   bypass_keep_a: assert property (
      (SOFT_RST && bypass_q && !wr_fire)
      |=> $stable(PULL_EN) && $stable(PULL_UP) && $stable(pol_q))
      else $error("soft reset not bypassed");

   soft_default_a: assert property (
      (SOFT_RST && !bypass_q)
      |=> (PULL_EN == RST_PULL_ENABLE) && (PULL_UP == RST_PULL_DIR) && (pol_q == RST_POL))
      else $error("soft reset did not restore");

   pull_en_a: assert property (
      (wr_fire && PADDR == OFS_PULL_ENABLE && !soft_kill)
      |=> PULL_EN == $past(PWDATA[15:0]) ##1 (PULL_EN == $past(PULL_EN)) || $past(wr_fire) || $past(soft_kill))
      else $error("pull enable not applied");

   pull_dir_a: assert property (
      (wr_fire && PADDR == OFS_PULL_DIR && !soft_kill)
      |=> PULL_UP == $past(PWDATA[15:0]))
      else $error("pull direction not applied");

   rsvd_zero_a: assert property (
      (fire && !PWRITE) |-> PRDATA[31:16] == RSVD_HIGH)
      else $error("reserved bits not zero");

   apb_wait_a: assert property (
      (PSEL && PENABLE && state_q == AP_IDLE) |=> PREADY ##1 !PREADY)
      else $error("apb answer timing wrong");

   irq_out_a: assert property (
      ##1 IRQ == $past(|(pending_q & mask_q)))
      else $error("interrupt output wrong");

   pol_set_a: assert property (
      (wr_fire && PADDR == OFS_POL_SET && !soft_kill)
      |=> pol_q == ($past(pol_q) | $past(wr_pins)))
      else $error("polarity set wrong");

   pol_hold_a: assert property (
      (!(wr_fire && (PADDR == OFS_POL_SET || PADDR == OFS_POL_CLEAR)) && !soft_kill)
      |=> pol_q == $past(pol_q))
      else $error("polarity changed unasked");

   // events lag pins by one edge; the detector is blind for one edge after reset
   event_pol_a: assert property (
      (!$past(SYS_RST) && !$past(SYS_RST, 2))
      |-> pin_events == (($past(pol_q) & $past(PIN_IN) & ~$past(PIN_IN, 2))
                         | (~$past(pol_q) & ~$past(PIN_IN) & $past(PIN_IN, 2))))
      else $error("edge event wrong");

   pend_hold_a: assert property (
      (!(wr_fire && PADDR == OFS_IRQ_STATUS) && !soft_kill)
      |=> (pending_q & $past(pending_q)) == $past(pending_q))
      else $error("pending bit lost");

   pend_rise_a: assert property (
      1'b1 |=> (pending_q & ~$past(pending_q) & ~$past(pin_events)) == 16'h0000)
      else $error("pending bit without event");

   bypass_wr_a: assert property (
      (wr_fire && PADDR == OFS_SOFT_RESET)
      |=> bypass_q == $past(PWDATA[BYPASS_BIT]))
      else $error("bypass bit not written");

   bypass_read_a: assert property (
      (fire && !PWRITE && PADDR == OFS_SOFT_RESET)
      |-> PRDATA == {31'h0000_0000, $past(bypass_q)})
      else $error("bypass readback wrong");

   pend_soft_a: assert property (
      (SOFT_RST && !bypass_q)
      |=> pending_q == $past(pin_events))
      else $error("soft reset left pending");

   mask_soft_a: assert property (
      (SOFT_RST && !(wr_fire && PADDR == OFS_IRQ_MASK))
      |=> $stable(mask_q))
      else $error("soft reset touched mask");

   mask_wr_a: assert property (
      (wr_fire && PADDR == OFS_IRQ_MASK)
      |=> mask_q == $past(wr_pins))
      else $error("mask not written");

   pull_en_read_a: assert property (
      (fire && !PWRITE && PADDR == OFS_PULL_ENABLE)
      |-> PRDATA == {RSVD_HIGH, $past(PULL_EN)})
      else $error("pull enable readback wrong");

   pull_dir_read_a: assert property (
      (fire && !PWRITE && PADDR == OFS_PULL_DIR)
      |-> PRDATA == {RSVD_HIGH, $past(PULL_UP)})
      else $error("pull direction readback wrong");

   err_read_a: assert property (
      (fire && !PWRITE && PSLVERR)
      |-> PRDATA == RST_RDATA)
      else $error("unmapped read not zero");

   err_write_a: assert property (
      (fire && PWRITE && PSLVERR && !SOFT_RST)
      |=> $stable(pol_q) && $stable(pull_en_q) && $stable(pull_dir_q)
          && $stable(mask_q) && $stable(bypass_q))
      else $error("unmapped write took effect");

   err_ready_a: assert property (
      PSLVERR |-> PREADY)
      else $error("error without ready");

   fire_ready_a: assert property (
      fire |-> PREADY)
      else $error("access edge without ready");

   rdata_idle_a: assert property (
      !PREADY |-> PRDATA == RST_RDATA)
      else $error("read data outside answer");
endmodule

// ---- hw/gpio_pkg.sv ----
// constants shared by the gpio interrupt and pull control block
// assumes a 32-bit apb master and a 16-pin port
package gpio_pkg;
   localparam int PIN_COUNT = 16;
   typedef logic [PIN_COUNT-1:0] pins_t;
   typedef logic [11:0] addr_t;
   typedef logic [31:0] word_t;

   // byte addresses of the registers
   localparam addr_t OFS_POL_SET = 12'h030;
   localparam addr_t OFS_POL_CLEAR = 12'h034;
   localparam addr_t OFS_IRQ_STATUS = 12'h038;
   localparam addr_t OFS_SOFT_RESET = 12'h03c;
   localparam addr_t OFS_PULL_ENABLE = 12'h040;
   localparam addr_t OFS_PULL_DIR = 12'h044;
   localparam addr_t OFS_IRQ_MASK = 12'h048;

   // field positions
   localparam int BYPASS_BIT = 0;
   localparam int PIN_LSB = 0;
   localparam int PIN_MSB = 15;

   // reset values
   localparam pins_t RST_POL = 16'h0000;
   localparam pins_t RST_PENDING = 16'h0000;
   localparam pins_t RST_PULL_ENABLE = 16'h0000;
   localparam pins_t RST_PULL_DIR = 16'h0000;
   localparam pins_t RST_MASK = 16'h0000;
   localparam logic RST_BYPASS = 1'b0;
   localparam word_t RST_RDATA = 32'h0000_0000;
   localparam logic [15:0] RSVD_HIGH = 16'h0000;
endpackage

// ---- hw/pin_edge_detect.sv ----
// per-pin edge detector producing one-cycle interrupt events
// assumes pin levels already synchronous to the clock
module pin_edge_detect (
   input wire logic clk,
   input wire logic rst,
   edge_if.det port
);
   import gpio_pkg::*;

   pins_t prev_q;
   pins_t event_q;
   logic armed_q;

   // no event on the first sample after reset, prev_q is not yet real
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= RST_PENDING;
      end else begin
         prev_q <= port.pins;
      end
   end

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_pin
         always_ff @(posedge clk) begin
            if (rst) begin
               event_q[i] <= 1'b0;
            end else if (port.polarity[i]) begin
               event_q[i] <= armed_q & port.pins[i] & ~prev_q[i];
            end else begin
               event_q[i] <= armed_q & ~port.pins[i] & prev_q[i];
            end
         end
      end
   endgenerate

   assign port.events = event_q;
endmodule

// ---- verification/pin_model.sv ----
// far-side pin model: drives or releases each port pin
// assumes pins move only just after a rising clock edge
module pin_model (
   input wire logic clk,
   input wire gpio_pkg::pins_t drive_val,
   input wire gpio_pkg::pins_t drive_en,
   input wire gpio_pkg::pins_t pull_en,
   input wire gpio_pkg::pins_t pull_up,
   output gpio_pkg::pins_t level
);
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_pkg::*;
   initial level = '0;
   // released pin without pull flips, so a stale level never looks valid
   always @(posedge clk) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         level[i] <= drive_en[i] ? drive_val[i] : (pull_en[i] ? pull_up[i] : ~level[i]);
      end
   end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the gpio interrupt and pull register block
// assumes apb answer within 20 cycles, pins driven by the pin model
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_pkg::*;
   logic core_clk, sys_rst, soft_rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
   addr_t paddr;
   word_t pwdata, rdata;
   logic [31:0] prdata;
   pins_t pin_in, pull_en, pull_up, drv_val, drv_en;
   int error_cnt, checked;

   gpio_irq_pull_regs dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PULL_EN(pull_en), .PULL_UP(pull_up), .IRQ(irq));
   pin_model u_pins (.clk(core_clk), .drive_val(drv_val), .drive_en(drv_en), .pull_en(pull_en),
      .pull_up(pull_up), .level(pin_in));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic final_report();
      $display("mismatches %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input word_t exp, input word_t got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   // one full apb transfer; data and error taken at the ready edge
   task automatic apb(input logic wr, input addr_t a, input word_t wd);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         chk("pready timeout", 1, 0);
         final_report();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input addr_t a, input word_t exp, input string name);
      apb(1'b0, a, '0);
      chk(name, exp, rdata);
   endtask

   task automatic pins_to(input pins_t v);
      @(posedge core_clk);
      drv_val <= v;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic soft_pulse();
      @(posedge core_clk);
      soft_rst <= 1'b1;
      @(posedge core_clk);
      soft_rst <= 1'b0;
   endtask

   task automatic t_reset();
      addr_t regs[7] = '{OFS_POL_SET, OFS_POL_CLEAR, OFS_IRQ_STATUS, OFS_SOFT_RESET, OFS_PULL_ENABLE,
         OFS_PULL_DIR, OFS_IRQ_MASK};
      foreach (regs[i]) rd_chk(regs[i], '0, "reset value");
      @(negedge core_clk);
      chk("pull_up", '0, 32'(pull_up));
      chk("irq", '0, 32'(irq));
   endtask

   task automatic t_polarity();
      apb(1'b1, OFS_POL_SET, 32'hffff_ffff);
      rd_chk(OFS_POL_CLEAR, 32'h0000_ffff, "pol all set");
      apb(1'b1, OFS_POL_CLEAR, 32'h0000_00f0);
      rd_chk(OFS_POL_CLEAR, 32'h0000_ff0f, "pol cleared");
   endtask

   // pin3 rising with pol one, pin4 falling with pol zero; only pin3 unmasked
   task automatic t_irq();
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0008);
      pins_to(16'h0018);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0008, "pending rise");
      chk("irq set", 1, 32'(irq));
      pins_to(16'h0000);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0018, "pending fall");
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0000);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0018, "zero write");
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0008);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0010, "w1c");
      @(negedge core_clk);
      chk("irq masked", 0, 32'(irq));
      apb(1'b1, OFS_IRQ_STATUS, 32'hffff_ffff);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0000, "all cleared");
   endtask

   task automatic t_pull();
      apb(1'b1, OFS_PULL_ENABLE, 32'hffff_00ff);
      apb(1'b1, OFS_PULL_DIR, 32'h5a5a_000f);
      rd_chk(OFS_PULL_ENABLE, 32'h0000_00ff, "pull enable");
      rd_chk(OFS_PULL_DIR, 32'h0000_000f, "pull dir");
      @(negedge core_clk);
      chk("pull_en", 32'h0000_00ff, 32'(pull_en));
      chk("pull_up", 32'h0000_000f, 32'(pull_up));
      // release the low byte: pins 3..0 pulled up rise, pins 7..4 stay pulled down
      @(posedge core_clk);
      drv_en <= 16'hff00;
      pins_to(16'h0000);
      rd_chk(OFS_IRQ_STATUS, 32'h0000_000f, "pulled edges");
      @(posedge core_clk);
      drv_en <= '1;
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_ffff);
   endtask

   task automatic t_soft();
      apb(1'b1, OFS_SOFT_RESET, 32'hffff_ffff);
      rd_chk(OFS_SOFT_RESET, 32'h0000_0001, "bypass");
      soft_pulse();
      rd_chk(OFS_POL_SET, 32'h0000_ff0f, "pol kept");
      chk("pull_en kept", 32'h0000_00ff, 32'(pull_en));
      apb(1'b1, OFS_SOFT_RESET, 32'h0000_0000);
      pins_to(16'h0008);
      soft_pulse();
      rd_chk(OFS_POL_SET, 32'h0000_0000, "pol restored");
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0000, "pending restored");
      rd_chk(OFS_IRQ_MASK, 32'h0000_0008, "mask kept");
      chk("pull_en restored", 0, 32'(pull_en));
      chk("pull_up restored", 0, 32'(pull_up));
      chk("irq restored", 0, 32'(irq));
   endtask

   // hard reset in mid-run: bypass bit and pull direction go back to zero, no false edge
   task automatic t_hard();
      apb(1'b1, OFS_SOFT_RESET, 32'h0000_0001);
      apb(1'b1, OFS_PULL_DIR, 32'h0000_00f0);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk(OFS_SOFT_RESET, 32'h0000_0000, "bypass after reset");
      rd_chk(OFS_PULL_DIR, 32'h0000_0000, "pull dir after reset");
      rd_chk(OFS_IRQ_STATUS, 32'h0000_0000, "pending after reset");
      chk("pull_up after reset", 0, 32'(pull_up));
      chk("irq after reset", 0, 32'(irq));
   endtask

   task automatic t_unmapped();
      apb(1'b1, 12'h100, 32'hffff_ffff);
      chk("slverr write", 1, 32'(rerr));
      rd_chk(12'h100, 32'h0000_0000, "unmapped data");
      chk("slverr read", 1, 32'(rerr));
   endtask

   initial begin
      sys_rst = 1'b1;
      soft_rst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      drv_val = '0;
      drv_en = '1;
      error_cnt = 0;
      checked = 0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_polarity();
      t_irq();
      t_pull();
      t_soft();
      t_unmapped();
      t_hard();
      final_report();
   end
endmodule
